// ### pin_model.sv
// Far-side pin model: external count clock and capture input pin
`timescale 1ns/1ps
module pin_model (
    input wire logic core_clk_i,
    output logic ext_clk_o,
    output logic capture_pin_o
);
    // Clock stands low between bursts, capture pin idles high as if pulled up
    initial begin
        ext_clk_o = 1'b0;
        capture_pin_o = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Burst of external clock periods, eight core cycles each
    task automatic ext_pulses(input int n);
        repeat (n) begin
            @(posedge core_clk_i);
            ext_clk_o <= 1'b1;
            repeat (4) @(posedge core_clk_i);
            ext_clk_o <= 1'b0;
            repeat (3) @(posedge core_clk_i);
        end
    endtask
    // One falling edge, held low long enough for the synchroniser
    task automatic capture_fall();
        @(posedge core_clk_i);
        capture_pin_o <= 1'b0;
        repeat (6) @(posedge core_clk_i);
        capture_pin_o <= 1'b1;
        repeat (2) @(posedge core_clk_i);
    endtask
endmodule

// ### reload_timer_with_capture.sv
// Reload timer with capture: APB registers, counter, capture and interrupt
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module reload_timer_with_capture
    import timer_two_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic ext_clk_i,
    input wire logic capture_input_pin_i,
    output logic irq_o
);
    logic [7:0] ctrl_q, ctrl_d;
    logic [7:0] cnt_l_q, cnt_l_d, cnt_h_q, cnt_h_d;
    logic [7:0] rld_l_q, rld_l_d, rld_h_q, rld_h_d;
    logic [1:0] choice_q, choice_d;
    logic [2:0] st_q, st_d, en_q, en_d;
    logic [31:0] prdata_d;
    logic pready_d, pslverr_d, irq_d;
    logic cap1_q, cap2_q, cap3_q;
    logic base_tick, tick_l, tick_h, inc_l, inc_h, lo_wrap, hi_wrap, cap_evt;
    logic access, wr_en, wr_ctrl, wr_cnt_l, wr_cnt_h, wr_rld_l, wr_rld_h;
    logic split, run;

    // Address decode shared by read and write paths
    function automatic logic mapped(input logic [11:0] a);
        mapped = (a == OFF_CONTROL) || (a == OFF_COUNT_LOW) || (a == OFF_COUNT_HIGH) ||
            (a == OFF_RELOAD_LOW) || (a == OFF_RELOAD_HIGH) || (a == OFF_CLOCK_CHOICE) ||
            (a == OFF_IRQ_STATUS) || (a == OFF_IRQ_CLEAR) || (a == OFF_IRQ_ENABLE);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Timebase
    timebase_gen u_timebase (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .ext_clk_i(ext_clk_i),
        .ext_select_i(ctrl_q[EXT_CLK_SEL_BIT]),
        .tick_o(base_tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Bus strobes
    always_comb begin
        access = psel_i & penable_i & pready_o;
        wr_en = access & pwrite_i & pstrb_i[0];
        wr_ctrl = wr_en & (paddr_i == OFF_CONTROL);
        wr_cnt_l = wr_en & (paddr_i == OFF_COUNT_LOW);
        wr_cnt_h = wr_en & (paddr_i == OFF_COUNT_HIGH);
        wr_rld_l = wr_en & (paddr_i == OFF_RELOAD_LOW);
        wr_rld_h = wr_en & (paddr_i == OFF_RELOAD_HIGH);
        split = ctrl_q[SPLIT_EN_BIT];
        run = ctrl_q[RUN_BIT];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Count enables and wraps
    always_comb begin
        // Per-byte choice: 1 picks the system clock, 0 the selected timebase
        tick_l = choice_q[LOW_CHOICE_BIT] | base_tick;
        tick_h = choice_q[HIGH_CHOICE_BIT] | base_tick;
        if (split) begin
            inc_l = tick_l;
            inc_h = run & tick_h;
        end else begin
            inc_l = run & tick_l;
            inc_h = inc_l & (cnt_l_q == BYTE_MAX);
        end
        lo_wrap = inc_l & (cnt_l_q == BYTE_MAX);
        hi_wrap = inc_h & (cnt_h_q == BYTE_MAX);
        cap_evt = ctrl_q[CAPTURE_EN_BIT] & cap3_q & ~cap2_q;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Counter and reload next values
    always_comb begin
        cnt_l_d = cnt_l_q;
        cnt_h_d = cnt_h_q;
        rld_l_d = rld_l_q;
        rld_h_d = rld_h_q;
        // Low byte: own reload in split mode, full reload on 16-bit wrap
        if (lo_wrap && (split || hi_wrap)) begin
            cnt_l_d = rld_l_q;
        end else if (inc_l) begin
            cnt_l_d = cnt_l_q + 8'h01;
        end
        if (hi_wrap) begin
            cnt_h_d = rld_h_q;
        end else if (inc_h) begin
            cnt_h_d = cnt_h_q + 8'h01;
        end
        // Capture overwrites the reload pair with the live count
        if (cap_evt) begin
            rld_l_d = cnt_l_q;
            rld_h_d = cnt_h_q;
        end
        // Software writes take priority over counting
        if (wr_cnt_l) begin
            cnt_l_d = pwdata_i[7:0];
        end
        if (wr_cnt_h) begin
            cnt_h_d = pwdata_i[7:0];
        end
        if (wr_rld_l) begin
            rld_l_d = pwdata_i[7:0];
        end
        if (wr_rld_h) begin
            rld_h_d = pwdata_i[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control, clock choice and interrupt next values
    always_comb begin
        ctrl_d = ctrl_q;
        choice_d = choice_q;
        en_d = en_q;
        st_d = st_q;
        if (wr_ctrl) begin
            ctrl_d = pwdata_i[7:0];
        end
        ctrl_d[RESERVED_BIT] = 1'b0;
        // Hardware sets win over a same-cycle software clear
        if (hi_wrap) begin
            ctrl_d[HIGH_FLAG_BIT] = 1'b1;
        end
        if (lo_wrap) begin
            ctrl_d[LOW_FLAG_BIT] = 1'b1;
        end
        if (wr_en && (paddr_i == OFF_CLOCK_CHOICE)) begin
            choice_d = pwdata_i[1:0];
        end
        if (wr_en && (paddr_i == OFF_IRQ_ENABLE)) begin
            en_d = pwdata_i[2:0];
        end
        if (wr_en && (paddr_i == OFF_IRQ_CLEAR)) begin
            st_d = st_q & ~pwdata_i[2:0];
        end
        st_d = st_d | {cap_evt, lo_wrap, hi_wrap};
        irq_d = (st_q[IRQ_HIGH_BIT] & en_q[IRQ_HIGH_BIT]) |
            (st_q[IRQ_LOW_BIT] & en_q[IRQ_LOW_BIT] & ctrl_q[LOW_IRQ_EN_BIT]) |
            (st_q[IRQ_CAPTURE_BIT] & en_q[IRQ_CAPTURE_BIT]);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data and answer, prepared in the setup cycle
    always_comb begin
        prdata_d = prdata_o;
        pready_d = psel_i & ~penable_i;
        pslverr_d = 1'b0;
        if (psel_i && !penable_i) begin
            pslverr_d = ~mapped(paddr_i);
            prdata_d = 32'h0000_0000;
            unique case (paddr_i)
                OFF_CONTROL: prdata_d[7:0] = ctrl_q;
                OFF_COUNT_LOW: prdata_d[7:0] = cnt_l_q;
                OFF_COUNT_HIGH: prdata_d[7:0] = cnt_h_q;
                OFF_RELOAD_LOW: prdata_d[7:0] = rld_l_q;
                OFF_RELOAD_HIGH: prdata_d[7:0] = rld_h_q;
                OFF_CLOCK_CHOICE: prdata_d[1:0] = choice_q;
                OFF_IRQ_STATUS: prdata_d[2:0] = st_q;
                OFF_IRQ_ENABLE: prdata_d[2:0] = en_q;
                default: prdata_d = 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State registers
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl_q <= CONTROL_RESET;
            cnt_l_q <= BYTE_RESET;
            cnt_h_q <= BYTE_RESET;
            rld_l_q <= BYTE_RESET;
            rld_h_q <= BYTE_RESET;
            choice_q <= CHOICE_RESET;
            st_q <= IRQ_RESET;
            en_q <= IRQ_RESET;
            irq_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            cap1_q <= 1'b1;
            cap2_q <= 1'b1;
            cap3_q <= 1'b1;
        end else begin
            ctrl_q <= ctrl_d;
            cnt_l_q <= cnt_l_d;
            cnt_h_q <= cnt_h_d;
            rld_l_q <= rld_l_d;
            rld_h_q <= rld_h_d;
            choice_q <= choice_d;
            st_q <= st_d;
            en_q <= en_d;
            irq_o <= irq_d;
            prdata_o <= prdata_d;
            pready_o <= pready_d;
            pslverr_o <= pslverr_d;
            cap1_q <= capture_input_pin_i;
            cap2_q <= cap1_q;
            cap3_q <= cap2_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);

    sequence full_wrap_s;
        !split && hi_wrap && !wr_cnt_l && !wr_cnt_h;
    endsequence

    high_flag_a: assert property (hi_wrap |=> ctrl_q[HIGH_FLAG_BIT] && st_q[IRQ_HIGH_BIT])
        else $error("high wrap did not set high flag");
    full_reload_a: assert property (full_wrap_s |=> cnt_h_q == $past(rld_h_q)
        && cnt_l_q == $past(rld_l_q))
        else $error("16-bit wrap did not reload count");
    high_irq_a: assert property (st_q[IRQ_HIGH_BIT] && en_q[IRQ_HIGH_BIT] |=> irq_o)
        else $error("enabled high overflow gave no interrupt");
    flag_sticky_a: assert property (ctrl_q[HIGH_FLAG_BIT] && !wr_ctrl
        |=> ctrl_q[HIGH_FLAG_BIT])
        else $error("high flag cleared by hardware");
    low_flag_a: assert property (lo_wrap |=> ctrl_q[LOW_FLAG_BIT])
        else $error("low wrap did not set low flag");
    low_mask_a: assert property (!ctrl_q[LOW_IRQ_EN_BIT] && !st_q[IRQ_HIGH_BIT]
        && !st_q[IRQ_CAPTURE_BIT] |=> !irq_o)
        else $error("low overflow interrupt not masked");
    capture_copy_a: assert property (cap_evt && !wr_rld_l && !wr_rld_h
        |=> rld_l_q == $past(cnt_l_q) && rld_h_q == $past(cnt_h_q) && st_q[IRQ_CAPTURE_BIT])
        else $error("capture did not copy the count");
    run_hold_a: assert property (!split && !run && !wr_cnt_l && !wr_cnt_h
        |=> $stable(cnt_l_q) && $stable(cnt_h_q))
        else $error("counter moved while stopped");
    split_low_a: assert property (split && !run && tick_l && !wr_cnt_l && !wr_cnt_h
        |=> cnt_l_q != $past(cnt_l_q) && $stable(cnt_h_q))
        else $error("split low byte did not run alone");
    reserved_zero_a: assert property (wr_ctrl |=> !ctrl_q[RESERVED_BIT])
        else $error("reserved control bit stored a one");
endmodule

// ### reload_timer_with_capture_tb_top.sv
// Self-checking bench for the reload timer: APB tasks and directed sequences
`timescale 1ns/1ps
module reload_timer_with_capture_tb_top;
    import timer_two_pkg::*;
    localparam int LIMIT = 20000;
    localparam logic [11:0] OFFS [8] = '{OFF_CONTROL, OFF_COUNT_LOW, OFF_COUNT_HIGH,
        OFF_RELOAD_LOW, OFF_RELOAD_HIGH, OFF_CLOCK_CHOICE, OFF_IRQ_STATUS, OFF_IRQ_ENABLE};
    logic core_clk_i;
    logic resetn_i;
    logic psel_i;
    logic penable_i;
    logic pwrite_i;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    logic ext_clk_i;
    logic capture_input_pin_i;
    logic irq_o;
    logic [31:0] rdata;
    logic rerr;
    logic [7:0] first_val;
    int bad_count = 0;
    int total_checks = 0;
    int cyc = 0;
    int t0;
    ////////////////////////////////////////////////////////////////////////////////
    // Design and far-side pins
    reload_timer_with_capture reload_timer_with_capture_inst (.core_clk_i(core_clk_i),
        .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(4'hF), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .ext_clk_i(ext_clk_i),
        .capture_input_pin_i(capture_input_pin_i), .irq_o(irq_o));
    pin_model pin_model_inst (.core_clk_i(core_clk_i), .ext_clk_o(ext_clk_i),
        .capture_pin_o(capture_input_pin_i));
    // Clock and hang guard
    initial begin
        core_clk_i = 1'b0;
        forever #10 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            bad_count++;
            print_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Verdict, comparison and bus tasks
    task automatic print_verdict();
        $display("Checks made %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [7:0] d);
        @(posedge core_clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= addr;
        pwdata_i <= {24'h000000, d};
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        do @(posedge core_clk_i); while (pready_o !== 1'b1);
        rdata = prdata_o;
        rerr = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] addr, input logic [7:0] d);
        apb(1'b1, addr, d);
    endtask
    task automatic rd_check(input string what, input logic [11:0] addr, input logic [7:0] exp);
        apb(1'b0, addr, 8'h00);
        check(what, rdata, {24'h000000, exp});
    endtask
    task automatic irq_check(input logic exp);
        repeat (3) @(posedge core_clk_i);
        check("irq line", {31'h0, irq_o}, {31'h0, exp});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Directed sequence
    initial begin
        resetn_i = 1'b0;
        psel_i = 1'b0;
        penable_i = 1'b0;
        pwrite_i = 1'b0;
        paddr_i = 12'h000;
        pwdata_i = 32'h0000_0000;
        repeat (16) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        for (int k = 0; k < 8; k++) rd_check("reset value", OFFS[k], 8'h00);
        wr(OFF_CONTROL, 8'h02);
        rd_check("reserved bit", OFF_CONTROL, 8'h00);
        apb(1'b0, 12'h030, 8'h00);
        check("unmapped error", {31'h0, rerr}, 32'h0000_0001);
        check("unmapped data", rdata, 32'h0000_0000);
        // Split mode, run off: only the low byte counts and reloads
        wr(OFF_CLOCK_CHOICE, 8'h01);
        wr(OFF_RELOAD_LOW, 8'h10);
        wr(OFF_COUNT_HIGH, 8'h55);
        wr(OFF_COUNT_LOW, 8'hF0);
        wr(OFF_CONTROL, 8'h08);
        repeat (30) @(posedge core_clk_i);
        rd_check("split flags", OFF_CONTROL, 8'h48);
        rd_check("held high byte", OFF_COUNT_HIGH, 8'h55);
        apb(1'b0, OFF_COUNT_LOW, 8'h00);
        check("low reloaded", {31'h0, rdata >= 32'h10 && rdata < 32'h40}, 32'h1);
        // Full 16-bit wrap reloads both bytes
        wr(OFF_CONTROL, 8'h00);
        wr(OFF_RELOAD_LOW, 8'h34);
        wr(OFF_RELOAD_HIGH, 8'h12);
        wr(OFF_COUNT_HIGH, 8'hFF);
        wr(OFF_COUNT_LOW, 8'hF0);
        wr(OFF_CONTROL, 8'h04);
        repeat (30) @(posedge core_clk_i);
        rd_check("wide flags", OFF_CONTROL, 8'hC4);
        rd_check("wide reload", OFF_COUNT_HIGH, 8'h12);
        wr(OFF_CONTROL, 8'hC0);
        // Interrupt enable, masking and clearing
        rd_check("status bits", OFF_IRQ_STATUS, 8'h03);
        wr(OFF_IRQ_ENABLE, 8'h01);
        irq_check(1'b1);
        wr(OFF_IRQ_ENABLE, 8'h02);
        irq_check(1'b0);
        wr(OFF_CONTROL, 8'hE0);
        irq_check(1'b1);
        wr(OFF_IRQ_ENABLE, 8'h00);
        irq_check(1'b0);
        repeat (200) @(posedge core_clk_i);
        rd_check("flags kept", OFF_CONTROL, 8'hE0);
        wr(OFF_IRQ_CLEAR, 8'h07);
        rd_check("status cleared", OFF_IRQ_STATUS, 8'h00);
        // Capture of a stopped count on a falling pin edge
        wr(OFF_COUNT_LOW, 8'hCD);
        wr(OFF_COUNT_HIGH, 8'hAB);
        wr(OFF_IRQ_ENABLE, 8'h04);
        wr(OFF_CONTROL, 8'h10);
        pin_model_inst.capture_fall();
        rd_check("capture low", OFF_RELOAD_LOW, 8'hCD);
        rd_check("capture high", OFF_RELOAD_HIGH, 8'hAB);
        rd_check("capture status", OFF_IRQ_STATUS, 8'h04);
        irq_check(1'b1);
        wr(OFF_IRQ_CLEAR, 8'h07);
        wr(OFF_IRQ_ENABLE, 8'h00);
        // System timebase: 240 cycles give 20 ticks
        wr(OFF_CLOCK_CHOICE, 8'h00);
        wr(OFF_CONTROL, 8'h04);
        t0 = cyc;
        apb(1'b0, OFF_COUNT_LOW, 8'h00);
        first_val = rdata[7:0];
        while (cyc < t0 + 240) @(posedge core_clk_i);
        apb(1'b0, OFF_COUNT_LOW, 8'h00);
        check("system ticks", {24'h0, rdata[7:0] - first_val}, 32'h0000_0014);
        // External timebase: 80 edges give 10 ticks
        wr(OFF_CONTROL, 8'h05);
        apb(1'b0, OFF_COUNT_LOW, 8'h00);
        first_val = rdata[7:0];
        pin_model_inst.ext_pulses(80);
        repeat (8) @(posedge core_clk_i);
        apb(1'b0, OFF_COUNT_LOW, 8'h00);
        check("external ticks", {24'h0, rdata[7:0] - first_val}, 32'h0000_000A);
        // Split with external source on the low byte only
        wr(OFF_CLOCK_CHOICE, 8'h02);
        wr(OFF_CONTROL, 8'h0D);
        apb(1'b0, OFF_COUNT_LOW, 8'h00);
        first_val = rdata[7:0];
        pin_model_inst.ext_pulses(16);
        repeat (8) @(posedge core_clk_i);
        apb(1'b0, OFF_COUNT_LOW, 8'h00);
        check("split external ticks", {24'h0, rdata[7:0] - first_val}, 32'h0000_0002);
        print_verdict();
    end
endmodule

// ### timebase_gen.sv
// Timebase for the timer: system clock over 12 or synchronised external clock over 8
`timescale 1ns/1ps
module timebase_gen
    import timer_two_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic ext_clk_i,
    input wire logic ext_select_i,
    output logic tick_o
);
    logic [3:0] sys_cnt_q, sys_cnt_d;
    logic [2:0] ext_cnt_q, ext_cnt_d;
    logic sync1_q, sync2_q, sync3_q;
    logic sys_tick, ext_edge, ext_tick, tick_d;

    ////////////////////////////////////////////////////////////////////////////
    // Next-state computation
    always_comb begin
        sys_tick = (sys_cnt_q == SYS_DIV_COUNT - 4'h1);
        sys_cnt_d = sys_tick ? 4'h0 : sys_cnt_q + 4'h1;
        ext_edge = sync2_q & ~sync3_q;
        ext_tick = ext_edge & (ext_cnt_q == EXT_DIV_COUNT);
        ext_cnt_d = ext_edge ? ext_cnt_q + 3'h1 : ext_cnt_q;
        tick_d = ext_select_i ? ext_tick : sys_tick;
    end

    // Registers, external clock through two sync flops first
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sys_cnt_q <= 4'h0;
            ext_cnt_q <= 3'h0;
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
            tick_o <= 1'b0;
        end else begin
            sys_cnt_q <= sys_cnt_d;
            ext_cnt_q <= ext_cnt_d;
            sync1_q <= ext_clk_i;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            tick_o <= tick_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);

    sys_period_a: assert property (sys_tick |-> ##12 sys_tick)
        else $error("system timebase period is not 12 cycles");
    ext_period_a: assert property (ext_tick |=> !ext_tick [*2])
        else $error("external tick came too soon");
endmodule

// ### timer_two_pkg.sv
// Constants, register map and field layout of the reload timer with capture
// Function
// - Control bits 7..0: high flag, low flag, low irq enable, capture, split, run, reserved, ext clock.
// - High overflow flag sets when the high byte wraps from 0xFF to 0x00.
// - In 16-bit mode the high flag sets on the 0xFFFF to 0x0000 wrap.
// - Enabled high overflow flag raises the timer interrupt request.
// - Overflow flags are never cleared by hardware, only by software.
// - Low overflow flag sets on every low byte wrap, in every mode.
// - Low byte overflow interrupts only with low irq enable and timer irq enabled.
// - Capture enabled: falling pin edge copies counter into reload pair, raises interrupt.
// - Split enable 0 gives one 16-bit counter, 1 gives two 8-bit counters.
// - In 16-bit mode the counter counts only while run control is 1, else holds.
// - In split mode run gates only the high byte; low byte always counts.
// - External clock select 0: timebase is system clock divided by 12.
// - External clock select 1: external clock divided by 8, synchronised first.
// - In split mode per-byte clock choices pick external tick or system clock.
// - Reload pair holds reload values, or captured counter bytes in capture mode.
// - Count bytes form one 16-bit count, or two independent 8-bit counts.
package timer_two_pkg;
    // Byte addresses of the word registers
    localparam logic [11:0] OFF_CONTROL = 12'h000;
    localparam logic [11:0] OFF_COUNT_LOW = 12'h004;
    localparam logic [11:0] OFF_COUNT_HIGH = 12'h008;
    localparam logic [11:0] OFF_RELOAD_LOW = 12'h00C;
    localparam logic [11:0] OFF_RELOAD_HIGH = 12'h010;
    localparam logic [11:0] OFF_CLOCK_CHOICE = 12'h014;
    localparam logic [11:0] OFF_IRQ_STATUS = 12'h018;
    localparam logic [11:0] OFF_IRQ_CLEAR = 12'h01C;
    localparam logic [11:0] OFF_IRQ_ENABLE = 12'h020;
    // Control register fields
    localparam int HIGH_FLAG_BIT = 7;
    localparam int LOW_FLAG_BIT = 6;
    localparam int LOW_IRQ_EN_BIT = 5;
    localparam int CAPTURE_EN_BIT = 4;
    localparam int SPLIT_EN_BIT = 3;
    localparam int RUN_BIT = 2;
    localparam int RESERVED_BIT = 1;
    localparam int EXT_CLK_SEL_BIT = 0;
    // Clock choice register fields
    localparam int LOW_CHOICE_BIT = 0;
    localparam int HIGH_CHOICE_BIT = 1;
    // Interrupt status, clear and enable fields
    localparam int IRQ_HIGH_BIT = 0;
    localparam int IRQ_LOW_BIT = 1;
    localparam int IRQ_CAPTURE_BIT = 2;
    // Values after reset
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [1:0] CHOICE_RESET = 2'h0;
    localparam logic [2:0] IRQ_RESET = 3'h0;
    // Timebase division counts and byte maximum
    localparam logic [3:0] SYS_DIV_COUNT = 4'hC;
    localparam logic [2:0] EXT_DIV_COUNT = 3'h7;
    localparam logic [7:0] BYTE_MAX = 8'hFF;
endpackage
